// [dv/wire_cmd_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wire_cmd_params.svh"

module wire_cmd_monitor
#(
  parameter int RESET_LOW_CYC = 80000
)
(
  // Bus side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Line side
  input wire logic link_clk,
  input wire logic line_o,
  input wire logic line_oe,
  input wire logic active_pullup_o,
  input wire logic strong_pullup_o
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic ap_q;
  logic [3:0] since_q;
  logic [31:0] low_q;
  wire logic ap_d = hsel & htrans[1] & hready & hwrite & (haddr[7:0] == `OFS_CMD);
  wire logic rd_ap = hsel & htrans[1] & hready & !hwrite;

  // Cycles since the last command word was committed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_q <= 1'b0;
      since_q <= 4'hF;
    end
    else
    begin
      ap_q <= ap_d;
      if (ap_q)
        since_q <= 4'h0;
      else if (since_q != 4'hF)
        since_q <= since_q + 4'h1;
    end
  end

  // Length of the current low drive in link cycles
  always_ff @(posedge link_clk or negedge hresetn)
  begin
    if (!hresetn)
      low_q <= 32'h0;
    else if (line_oe)
      low_q <= low_q + 32'h1;
    else
      low_q <= 32'h0;
  end

  bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0) else $error("error response seen");
  read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_ap |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  write_nowait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ap_d |=> hreadyout) else $error("write stalled");
  hrdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
  oe_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(line_oe) |-> since_q <= 4'h5) else $error("line activity late or unasked");
  low_bound_a: assert property (@(posedge link_clk) disable iff (!hresetn)
    low_q <= RESET_LOW_CYC) else $error("low drive too long");
  line_drive_a: assert property (@(posedge link_clk) disable iff (!hresetn)
    line_o == 1'b0) else $error("line driven high");
  spu_excl_a: assert property (@(posedge link_clk) disable iff (!hresetn)
    line_oe && $past(line_oe) |-> !strong_pullup_o) else $error("strong pullup while low");
  apu_excl_a: assert property (@(posedge link_clk) disable iff (!hresetn)
    line_oe && $past(line_oe) |-> !active_pullup_o) else $error("active pullup while low");
endmodule

bind wire_reset_and_single_bit_cmds wire_cmd_monitor #(.RESET_LOW_CYC(RESET_LOW_CYC)) mon
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .link_clk(link_clk), .line_o(line_o), .line_oe(line_oe),
  .active_pullup_o(active_pullup_o), .strong_pullup_o(strong_pullup_o)
);

`default_nettype wire

// [dv/wire_reset_and_single_bit_cmds_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wire_cmd_params.svh"

module wire_reset_and_single_bit_cmds_tb_top;
  import wire_cmd_pkg::*;
  localparam int RST_LOW = 80000;
  localparam int RST_HIGH = 80000;
  localparam int SLOT = 11667;
  localparam int WZ = 10000;
  localparam int W1 = 1000;
  logic hclk = 1'b0;
  logic link_clk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic present = 1'b1;
  logic shorted = 1'b0;
  logic read_bit = 1'b1;
  logic od = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, line_o, line_oe, apu_o, spu_o, line_w;
  int error_cnt = 0;
  int check_count = 0;
  int oe_rises = 0;
  int apu_rises = 0;
  int low_cnt = 0;
  int low_len = 0;
  logic [31:0] rd;
  realtime t0;
  logic [7:0] pb [4] = '{8'h80, 8'h7F, 8'hFF, 8'h00};
  logic rb [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic res [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic ap [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  int lo [4] = '{W1, WZ, W1, WZ};

  always #25 hclk = ~hclk;
  initial #1.7 forever #3 link_clk = ~link_clk;
  always @(posedge line_oe) oe_rises++;
  always @(posedge apu_o) apu_rises++;
  always @(posedge link_clk)
  begin
    if (line_oe)
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0)
    begin
      low_len <= low_cnt;
      low_cnt <= 0;
    end
  end

  wire_reset_and_single_bit_cmds #(.RESET_LOW_CYC(RST_LOW), .RESET_HIGH_CYC(RST_HIGH)) dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
    .line_i(line_w), .line_o(line_o), .line_oe(line_oe),
    .active_pullup_o(apu_o), .strong_pullup_o(spu_o)
  );

  wire_slave_model slave
  (
    .line_oe(line_oe), .line_w(line_w), .present(present), .shorted(shorted),
    .read_bit(read_bit), .overdrive(od)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp, what);
  endtask

  task automatic wait_idle(output logic [31:0] st);
    do bus(1'b0, `OFS_STATUS, 32'h0, st); while (st[`ST_BUSY_BIT] !== 1'b0);
  endtask

  function automatic logic [31:0] stw(bit bz, bit pr, bit sh, bit rs, bit dr, bit rf);
    return {26'h0, rf, dr, rs, sh, pr, bz};
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #(100000 * 50);
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    expect_rd(`OFS_STATUS, 32'h0, "status reset");
    expect_rd(`OFS_CONFIG, 32'h0, "config reset");
    expect_rd(`OFS_POINTER, {24'h0, `RST_PTR}, "pointer reset");
    wr(8'h14, 32'hFFFF_FFFF);
    expect_rd(8'h14, 32'h0, "unmapped");
    $display("test register reset done");
    wr(`OFS_POINTER, {24'h0, `PTR_READ_DATA});
    wr(`OFS_CMD, {24'h0, `CODE_LINE_RESET});
    t0 = $realtime;
    expect_rd(`OFS_READ_PORT, stw(1, 0, 0, 0, 0, 0), "busy polled");
    wr(`OFS_CMD, {16'h8000, `CODE_SINGLE_SLOT});
    expect_rd(`OFS_STATUS, stw(1, 0, 0, 0, 0, 1), "slot refused");
    wr(`OFS_CMD, {24'h0, `CODE_LINE_RESET});
    wait_idle(rd);
    check(rd, stw(0, 1, 0, 0, 0, 1), "reset status");
    check(32'(oe_rises), 32'h1, "single low pulse");
    check(32'(low_len), 32'(RST_LOW), "reset low");
    check(32'($realtime - t0 >= (RST_LOW + RST_HIGH) * 6.0), 32'h1, "busy span");
    check(32'($realtime - t0 < (RST_LOW + RST_HIGH) * 6.0 + 3000), 32'h1, "busy end");
    expect_rd(`OFS_POINTER, {24'h0, `PTR_STATUS}, "pointer moved");
    $display("test standard reset done");
    od <= 1'b1;
    shorted <= 1'b1;
    wr(`OFS_CONFIG, 32'h4);
    wr(`OFS_CMD, {24'h0, `CODE_LINE_RESET});
    wait_idle(rd);
    check(rd, stw(0, 1, 1, 0, 0, 0), "short status");
    check(32'(low_len), 32'(RST_LOW / 8), "fast reset low");
    shorted <= 1'b0;
    present <= 1'b0;
    wr(`OFS_CMD, {24'h0, `CODE_LINE_RESET});
    wait_idle(rd);
    check(rd, stw(0, 0, 0, 0, 0, 0), "no presence");
    od <= 1'b0;
    $display("test fast reset done");
    for (int i = 0; i < 4; i++)
    begin
      read_bit <= rb[i];
      wr(`OFS_CONFIG, {31'h0, ap[i]});
      oe_rises = 0;
      apu_rises = 0;
      wr(`OFS_CMD, {16'h0, pb[i], `CODE_SINGLE_SLOT});
      t0 = $realtime;
      wait_idle(rd);
      check(rd, stw(0, 0, 0, res[i], res[i], 0), "slot status");
      check(32'(low_len), 32'(lo[i]), "slot low");
      check(32'(oe_rises), 32'h1, "one slot");
      check(32'(apu_rises != 0), 32'(ap[i]), "active pullup");
      check(32'($realtime - t0 >= SLOT * 6.0), 32'h1, "slot span");
    end
    $display("test single slots done");
    wr(`OFS_CONFIG, 32'h2);
    wr(`OFS_POINTER, {24'h0, `PTR_CONFIG});
    wr(`OFS_CMD, {16'h8000, `CODE_SINGLE_SLOT});
    wait_idle(rd);
    check(32'(spu_o), 32'h1, "strong pullup on");
    expect_rd(`OFS_POINTER, {24'h0, `PTR_STATUS}, "slot pointer");
    $display("test strong pullup done");
    report_and_stop();
  end
endmodule

`default_nettype wire

// [dv/wire_slave_model.sv]
`timescale 1ns/10ps
`default_nettype none

module wire_slave_model
(
  // Line
  input wire logic line_oe,
  output logic line_w,
  // Behaviour
  input wire logic present,
  input wire logic shorted,
  input wire logic read_bit,
  input wire logic overdrive
);
  logic pull;
  real div;
  realtime rise_t;

  initial pull = 1'b0;
  initial rise_t = 0;
  always_comb div = overdrive ? 8.0 : 1.0;
  // Pull-up holds the released line high
  assign line_w = !(line_oe | pull | shorted);

  // ----------------------------------------------------------------
  // Slot and presence answers
  // ----------------------------------------------------------------
  always @(posedge line_oe)
  begin
    rise_t = $realtime;
    if (!read_bit)
    begin
      pull = 1'b1;
      #(15000.0 / div) pull = 1'b0;
    end
  end

  always @(negedge line_oe)
  begin
    if ($realtime - rise_t > 100000.0 / div)
    begin
      #(15000.0 / div) pull = present;
      #(105000.0 / div) pull = 1'b0;
    end
  end
endmodule

`default_nettype wire

// [pkg/wire_cmd_params.svh]
`ifndef WIRE_CMD_PARAMS_SVH
`define WIRE_CMD_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte offsets)
// ----------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_CONFIG 8'h08
`define OFS_POINTER 8'h0C
`define OFS_READ_PORT 8'h10

// ----------------------------------------------------------------
// Command and pointer codes
// ----------------------------------------------------------------
`define CODE_LINE_RESET 8'hB4
`define CODE_SINGLE_SLOT 8'h87
`define PTR_STATUS 8'hF0
`define PTR_READ_DATA 8'hE1
`define PTR_CONFIG 8'hC3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMD_CODE_LSB 0
`define CMD_PARAM_LSB 8
`define CMD_SLOT_VALUE_BIT 15
`define ST_BUSY_BIT 0
`define ST_PRESENCE_BIT 1
`define ST_SHORT_BIT 2
`define ST_RESULT_BIT 3
`define ST_DIR_BIT 4
`define ST_REFUSED_BIT 5
`define CFG_APU_BIT 0
`define CFG_SPU_BIT 1
`define CFG_SPEED_BIT 2
`define PTR_CODE_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PTR 8'hF0
`define RST_WORD 32'h0000_0000

// ----------------------------------------------------------------
// Line timing, standard speed, in ns except the link period in ps and the overdrive shift count
// ----------------------------------------------------------------
`define LINK_PERIOD_PS 6000
`define RESET_LOW_NS 480000
`define RESET_HIGH_NS 480000
`define SHORT_SAMPLE_NS 8000
`define PRESENCE_SAMPLE_NS 70000
`define SLOT_NS 70000
`define WRITE_ZERO_LOW_NS 60000
`define WRITE_ONE_LOW_NS 6000
`define READ_SAMPLE_NS 10000
`define APU_NS 2000
`define OVERDRIVE_SHIFT 3

`endif

// [pkg/wire_cmd_pkg.sv]
package wire_cmd_pkg;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_LOW = 2'b01,
    L_REL = 2'b11,
    L_DONE = 2'b10
  } link_state_t;

  typedef struct packed {
    logic is_reset;
    logic slot_value;
  } cmd_t;

  typedef struct packed {
    logic active_pullup_enable;
    logic strong_pullup_enable;
    logic speed;
  } cfg_t;

  typedef struct packed {
    logic short_seen;
    logic presence;
    logic bit_value;
  } result_t;

endpackage

// [src/wire_reset_and_single_bit_cmds.sv]
// Contract
// - Line-reset code, no parameter, makes a reset low pulse then presence window.
// - Reset cycle samples line at short and presence instants into status bits.
// - Reset activity starts within 262.5ns; busy held for reset low plus high.
// - Reset code while busy is refused and ignored entirely.
// - Accepted reset points the read pointer at status.
// - Both commands use line speed, active pullup and strong pullup settings.
// - Single-slot code plus one parameter byte makes exactly one time slot.
// - Value zero makes a write-zero slot; value one a write-one/read slot.
// - Either slot samples the line at the read instant into the result bit.
// - Slot activity starts within 262.5ns; busy held for one slot duration.
// - Single-slot code while busy is refused, parameter too, and ignored.
// - Single-slot command points the read pointer at status.
// - Single slot may change the branch-direction bit besides busy and result.
// - Only parameter bit 7 carries the slot value; other bits ignored.
`timescale 1ns/10ps
`default_nettype none
`include "wire_cmd_params.svh"

module wire_reset_and_single_bit_cmds
  import wire_cmd_pkg::*;
#(
  parameter int CNT_W = 20,
  parameter int RESET_LOW_CYC =
    (`RESET_LOW_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS,
  parameter int RESET_HIGH_CYC =
    (`RESET_HIGH_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS,
  parameter int PRESENCE_CYC =
    (`PRESENCE_SAMPLE_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS,
  parameter int SLOT_CYC =
    (`SLOT_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS,
  parameter int WRITE_ZERO_CYC =
    (`WRITE_ZERO_LOW_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS
)
(
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Single-wire line
  input wire logic link_clk,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe,
  output logic active_pullup_o,
  output logic strong_pullup_o
);

  // ----------------------------------------------------------------
  // Derived line counts
  // ----------------------------------------------------------------
  localparam int SHORT_CYC =
    (`SHORT_SAMPLE_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS;
  localparam int WRITE_ONE_CYC =
    (`WRITE_ONE_LOW_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS;
  localparam int READ_CYC =
    (`READ_SAMPLE_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS;
  localparam int APU_CYC =
    (`APU_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS;
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  // ----------------------------------------------------------------
  // Bus-side state
  // ----------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_wait_q;
  logic [7:0] rd_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic busy_q;
  logic refused_q;
  logic dir_q;
  result_t res_q;
  cfg_t cfg_q;
  cmd_t cmd_q;
  logic [7:0] ptr_q;
  logic start_tgl_q;
  logic done_s1_q;
  logic done_s2_q;
  logic done_s3_q;
  logic done_edge;
  logic addr_ok;
  logic wr_cmd;
  logic [7:0] code;
  logic cmd_known;
  logic cmd_accept;
  logic [31:0] status_word;
  logic [31:0] config_word;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Link-side state
  // ----------------------------------------------------------------
  logic lrst_s1_q;
  logic lrst_n_q;
  logic st_s1_q;
  logic st_s2_q;
  logic st_s3_q;
  logic start_edge;
  cfg_t cfg_s1_q;
  cfg_t cfg_s2_q;
  logic line_s1_q;
  logic line_s2_q;
  link_state_t lstate_q;
  logic [CNT_W-1:0] cnt_q;
  cmd_t lcmd_q;
  result_t lres_q;
  logic done_tgl_q;
  logic line_oe_q;
  logic line_o_q;
  logic apu_q;
  logic spu_q;
  logic [CNT_W-1:0] apu_cnt_q;
  logic [CNT_W-1:0] low_len;
  logic [CNT_W-1:0] tot_len;
  logic [CNT_W-1:0] samp_a;
  logic [CNT_W-1:0] samp_b;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_cmd = wr_pend_q && (wr_addr_q == `OFS_CMD);
  assign code = hwdata[`CMD_CODE_LSB +: 8];
  assign cmd_known = (code == `CODE_LINE_RESET) || (code == `CODE_SINGLE_SLOT);
  assign cmd_accept = wr_cmd && cmd_known && !busy_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_wait_q <= 1'b0;
      rd_addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok)
      begin
        wr_addr_q <= haddr[7:0];
        rd_addr_q <= haddr[7:0];
      end
      // Reads take one wait state so a write just before is seen
      rd_wait_q <= addr_ok && !hwrite;
      if (addr_ok && !hwrite)
      begin
        hreadyout_q <= 1'b0;
      end
      else
      begin
        hreadyout_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp_q <= 1'b0;
    end
    else
    begin
      hresp_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    status_word = `RST_WORD;
    status_word[`ST_BUSY_BIT] = busy_q;
    status_word[`ST_PRESENCE_BIT] = res_q.presence;
    status_word[`ST_SHORT_BIT] = res_q.short_seen;
    status_word[`ST_RESULT_BIT] = res_q.bit_value;
    status_word[`ST_DIR_BIT] = dir_q;
    status_word[`ST_REFUSED_BIT] = refused_q;
    config_word = `RST_WORD;
    config_word[`CFG_APU_BIT] = cfg_q.active_pullup_enable;
    config_word[`CFG_SPU_BIT] = cfg_q.strong_pullup_enable;
    config_word[`CFG_SPEED_BIT] = cfg_q.speed;
  end

  always_comb
  begin
    rd_word = `RST_WORD;
    case (rd_addr_q)
      `OFS_STATUS: rd_word = status_word;
      `OFS_CONFIG: rd_word = config_word;
      `OFS_POINTER: rd_word = {24'h000000, ptr_q};
      `OFS_READ_PORT:
      begin
        if (ptr_q == `PTR_STATUS)
        begin
          rd_word = status_word;
        end
        else if (ptr_q == `PTR_CONFIG)
        begin
          rd_word = config_word;
        end
        else
        begin
          rd_word = `RST_WORD;
        end
      end
      default: rd_word = `RST_WORD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= `RST_WORD;
    end
    else if (rd_wait_q)
    begin
      hrdata_q <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and read pointer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q <= '0;
    end
    else if (wr_pend_q && (wr_addr_q == `OFS_CONFIG) && !busy_q)
    begin
      // Settings stay fixed while a command runs on the line
      cfg_q.active_pullup_enable <= hwdata[`CFG_APU_BIT];
      cfg_q.strong_pullup_enable <= hwdata[`CFG_SPU_BIT];
      cfg_q.speed <= hwdata[`CFG_SPEED_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ptr_q <= `RST_PTR;
    end
    else if (cmd_accept)
    begin
      ptr_q <= `PTR_STATUS;
    end
    else if (wr_pend_q && (wr_addr_q == `OFS_POINTER))
    begin
      if ((hwdata[`PTR_CODE_LSB +: 8] == `PTR_STATUS) ||
          (hwdata[`PTR_CODE_LSB +: 8] == `PTR_READ_DATA) ||
          (hwdata[`PTR_CODE_LSB +: 8] == `PTR_CONFIG))
      begin
        ptr_q <= hwdata[`PTR_CODE_LSB +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command launch and completion
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_q <= '0;
      start_tgl_q <= 1'b0;
    end
    else if (cmd_accept)
    begin
      cmd_q.is_reset <= (code == `CODE_LINE_RESET);
      cmd_q.slot_value <= hwdata[`CMD_SLOT_VALUE_BIT];
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end
    else
    begin
      done_s1_q <= done_tgl_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  assign done_edge = done_s2_q ^ done_s3_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_q <= 1'b0;
    end
    else if (cmd_accept)
    begin
      busy_q <= 1'b1;
    end
    else if (done_edge)
    begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      refused_q <= 1'b0;
    end
    else if (wr_cmd && cmd_known)
    begin
      refused_q <= busy_q;
    end
  end

  // Results held by the link side stay stable after its done toggle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      res_q <= '0;
      dir_q <= 1'b0;
    end
    else if (done_edge)
    begin
      if (cmd_q.is_reset)
      begin
        res_q.short_seen <= lres_q.short_seen;
        res_q.presence <= lres_q.presence;
      end
      else
      begin
        res_q.bit_value <= lres_q.bit_value;
        dir_q <= lres_q.bit_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link clock domain: reset and crossings
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lrst_s1_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end
    else
    begin
      lrst_s1_q <= 1'b1;
      lrst_n_q <= lrst_s1_q;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_q)
  begin
    if (!lrst_n_q)
    begin
      st_s1_q <= 1'b0;
      st_s2_q <= 1'b0;
      st_s3_q <= 1'b0;
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end
    else
    begin
      st_s1_q <= start_tgl_q;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
      cfg_s1_q <= cfg_q;
      cfg_s2_q <= cfg_s1_q;
      line_s1_q <= line_i;
      line_s2_q <= line_s1_q;
    end
  end

  assign start_edge = st_s2_q ^ st_s3_q;

  // ----------------------------------------------------------------
  // Waveform lengths for the running command
  // ----------------------------------------------------------------
  always_comb
  begin
    if (lcmd_q.is_reset)
    begin
      low_len = CNT_W'(RESET_LOW_CYC);
      tot_len = CNT_W'(RESET_LOW_CYC + RESET_HIGH_CYC);
      samp_a = CNT_W'(RESET_LOW_CYC + SHORT_CYC);
      samp_b = CNT_W'(RESET_LOW_CYC + PRESENCE_CYC);
    end
    else
    begin
      low_len = lcmd_q.slot_value ? CNT_W'(WRITE_ONE_CYC) : CNT_W'(WRITE_ZERO_CYC);
      tot_len = CNT_W'(SLOT_CYC);
      samp_a = CNT_W'(READ_CYC);
      samp_b = CNT_W'(READ_CYC);
    end
    if (cfg_s2_q.speed)
    begin
      // Overdrive shortens the low, total and sample intervals by the same factor
      low_len = low_len >> `OVERDRIVE_SHIFT;
      tot_len = tot_len >> `OVERDRIVE_SHIFT;
      samp_a = samp_a >> `OVERDRIVE_SHIFT;
      samp_b = samp_b >> `OVERDRIVE_SHIFT;
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge lrst_n_q)
  begin
    if (!lrst_n_q)
    begin
      lstate_q <= L_IDLE;
      cnt_q <= '0;
      lcmd_q <= '0;
      done_tgl_q <= 1'b0;
      line_oe_q <= 1'b0;
    end
    else
    begin
      case (lstate_q)
        L_IDLE:
        begin
          if (start_edge)
          begin
            lcmd_q <= cmd_q;
            cnt_q <= '0;
            line_oe_q <= 1'b1;
            lstate_q <= L_LOW;
          end
        end
        L_LOW:
        begin
          cnt_q <= cnt_q + ONE;
          if (cnt_q >= low_len - ONE)
          begin
            line_oe_q <= 1'b0;
            lstate_q <= L_REL;
          end
        end
        L_REL:
        begin
          cnt_q <= cnt_q + ONE;
          if (cnt_q >= tot_len - ONE)
          begin
            lstate_q <= L_DONE;
          end
        end
        L_DONE:
        begin
          done_tgl_q <= ~done_tgl_q;
          lstate_q <= L_IDLE;
        end
        default:
        begin
          line_oe_q <= 1'b0;
          lstate_q <= L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_q)
  begin
    if (!lrst_n_q)
    begin
      lres_q <= '0;
    end
    else if (lstate_q == L_LOW || lstate_q == L_REL)
    begin
      if (lcmd_q.is_reset && cnt_q == samp_a)
      begin
        lres_q.short_seen <= ~line_s2_q;
      end
      if (lcmd_q.is_reset && cnt_q == samp_b)
      begin
        lres_q.presence <= ~line_s2_q;
      end
      if (!lcmd_q.is_reset && cnt_q == samp_b)
      begin
        lres_q.bit_value <= line_s2_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pullup drives
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge lrst_n_q)
  begin
    if (!lrst_n_q)
    begin
      apu_q <= 1'b0;
      apu_cnt_q <= '0;
    end
    else if (lstate_q == L_LOW && cnt_q >= low_len - ONE && cfg_s2_q.active_pullup_enable)
    begin
      // Brief active pull right after release speeds the rising edge
      apu_q <= 1'b1;
      apu_cnt_q <= CNT_W'(APU_CYC);
    end
    else if (apu_cnt_q > ONE)
    begin
      apu_cnt_q <= apu_cnt_q - ONE;
    end
    else
    begin
      apu_q <= 1'b0;
      apu_cnt_q <= '0;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_q)
  begin
    if (!lrst_n_q)
    begin
      spu_q <= 1'b0;
    end
    else if (start_edge)
    begin
      spu_q <= 1'b0;
    end
    else if (lstate_q == L_DONE)
    begin
      // Strong pull holds the line up after the command until the next one
      spu_q <= cfg_s2_q.strong_pullup_enable;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_q)
  begin
    if (!lrst_n_q)
    begin
      line_o_q <= 1'b0;
    end
    else
    begin
      line_o_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign line_o = line_o_q;
  assign line_oe = line_oe_q;
  assign active_pullup_o = apu_q;
  assign strong_pullup_o = spu_q;

endmodule

`default_nettype wire
